/* dcfb_bank_ctrl.sv */
// Purpose: control of one 18-bit fifo bank: clear, writes, reads, flags, offsets
// Assumes: write and read sides share clk (the coincident-clock case)
// Notes: straps are sampled while clear is held; flags come from exact counts
module dcfb_bank_ctrl (
  // clocking and reset
  input wire logic clk,
  input wire logic reset,
  // bank clear and configuration straps
  input wire logic fifo_clear_n,
  input wire logic first_device_select,
  input wire logic chain_read_in,
  input wire logic chain_write_in,
  // write side
  input wire logic [17:0] data_in,
  input wire logic write_enable_n,
  input wire logic offset_load_n,
  // read side
  input wire logic read_enable_n,
  input wire logic output_enable_n,
  output logic [17:0] data_out,
  output logic data_out_oe,
  // status flags
  output logic full_flag,
  output logic input_ready,
  output logic empty_flag,
  output logic output_ready,
  output logic half_full_flag,
  output logic almost_full_flag,
  output logic almost_empty_flag
);

  typedef struct packed {
    logic clr_meta;
    logic clr_s;
    logic [2:0] strap_meta;
    logic [2:0] strap_s;
    logic fall_mode;
    logic dbl;
    logic part_sync;
    logic [17:0] out_data;
    logic out_valid;
    logic [1:0] fall_stage;
    logic [11:0] empty_off;
    logic [11:0] full_off;
    dcfb_pkg::dcfb_osel_e osel_w;
    dcfb_pkg::dcfb_osel_e osel_r;
    logic full_f;
    logic empty_f;
    logic in_rdy;
    logic half_f;
    logic afull_f;
    logic aempty_f;
    logic full_d;
    logic empty_d;
    logic in_rdy_d;
  } dcfb_state_s;

  // clear synchroniser starts low so every reset also passes a clear
  localparam dcfb_state_s ST_RST = '{
    osel_w: dcfb_pkg::OSEL_EMPTY,
    osel_r: dcfb_pkg::OSEL_EMPTY,
    empty_off: dcfb_pkg::EMPTY_OFF_DEF,
    full_off: dcfb_pkg::FULL_OFF_DEF,
    full_f: 1'b1,
    full_d: 1'b1,
    half_f: 1'b1,
    afull_f: 1'b1,
    default: '0
  };

  // returns {half, almost_full, almost_empty} pin levels for a fill level
  function automatic logic [2:0] dcfb_levels(input logic [12:0] lvl, input logic fall_mode,
                                             input logic [11:0] eoff, input logic [11:0] foff);
    logic [12:0] extra;
    extra = {12'h000, fall_mode};
    dcfb_levels[2] = !(lvl > dcfb_pkg::HALF_LEVEL + extra);
    dcfb_levels[1] = !(lvl >= dcfb_pkg::DEPTH_LEVEL + extra - {1'b0, foff});
    dcfb_levels[0] = !(lvl <= {1'b0, eoff} + extra);
  endfunction

  function automatic logic [12:0] dcfb_fill(input logic [8:0] cnt, input logic ov);
    dcfb_fill = {4'h0, cnt} + {12'h000, ov};
  endfunction

  dcfb_state_s st_reg;
  dcfb_state_s st_next;

  logic [8:0] cnt;
  logic [8:0] cnt_nx;
  logic [17:0] store_data;
  logic store_valid;
  logic store_ready;
  logic wr_go;
  logic push;
  logic pop;
  logic std_read;
  logic fall_read;
  logic fall_load;
  logic off_wr;
  logic off_rd;
  logic [12:0] level_nx;
  logic [2:0] lv_next;
  logic [2:0] lv_now;

  // storage depth and count come from the fifo module, sized by the package
  dcfb_store #(
    .WIDTH(dcfb_pkg::DATA_W),
    .DEPTH(dcfb_pkg::DEPTH)
  ) u_store (
    .clk(clk),
    .reset(reset),
    .clear(!st_reg.clr_s),
    .wr_valid(wr_go),
    .wr_data(data_in),
    .wr_ready(store_ready),
    .rd_valid(store_valid),
    .rd_data(store_data),
    .rd_ready(pop),
    .count(cnt)
  );

  // full is taken from the exact internal flag so a buffered pin never lets a write slip
  assign wr_go = !write_enable_n && offset_load_n && st_reg.clr_s && store_ready
                 && (st_reg.fall_mode ? !st_reg.in_rdy : st_reg.full_f);
  assign push = wr_go;
  assign std_read = !st_reg.fall_mode && !read_enable_n && offset_load_n && st_reg.clr_s
                    && st_reg.empty_f && store_valid;
  assign fall_read = st_reg.fall_mode && st_reg.out_valid && !read_enable_n && offset_load_n
                     && st_reg.clr_s;
  assign fall_load = st_reg.fall_mode && !st_reg.out_valid && store_valid && st_reg.clr_s
                     && (st_reg.fall_stage == dcfb_pkg::FALL_STAGES);
  assign pop = std_read || fall_load || (fall_read && store_valid);
  assign off_wr = !offset_load_n && !write_enable_n && st_reg.clr_s;
  // a same-cycle offset write wins; the outside is not meant to overlap them
  assign off_rd = !offset_load_n && !read_enable_n && !st_reg.fall_mode && st_reg.clr_s
                  && !off_wr;
  assign cnt_nx = cnt + 9'(push) - 9'(pop);

  always_comb begin
    st_next = st_reg;
    level_nx = 13'h0000;
    lv_next = 3'h0;
    st_next.clr_meta = fifo_clear_n;
    st_next.clr_s = st_reg.clr_meta;
    st_next.strap_meta = {first_device_select, chain_read_in, chain_write_in};
    st_next.strap_s = st_reg.strap_meta;
    if (!st_reg.clr_s) begin
      st_next.fall_mode = !st_reg.strap_s[dcfb_pkg::STRAP_CHAIN_RD]
                          && st_reg.strap_s[dcfb_pkg::STRAP_CHAIN_WR];
      st_next.dbl = st_reg.strap_s[dcfb_pkg::STRAP_CHAIN_RD]
                    && !st_reg.strap_s[dcfb_pkg::STRAP_CHAIN_WR];
      st_next.part_sync = st_reg.strap_s[dcfb_pkg::STRAP_FIRST]
                          && !(st_reg.strap_s[dcfb_pkg::STRAP_CHAIN_RD]
                          && st_reg.strap_s[dcfb_pkg::STRAP_CHAIN_WR]);
      st_next.out_data = 18'h0_0000;
      st_next.out_valid = 1'b0;
      st_next.fall_stage = 2'h0;
      st_next.empty_off = dcfb_pkg::EMPTY_OFF_DEF;
      st_next.full_off = dcfb_pkg::FULL_OFF_DEF;
      st_next.osel_w = dcfb_pkg::OSEL_EMPTY;
      st_next.osel_r = dcfb_pkg::OSEL_EMPTY;
      st_next.full_f = 1'b1;
      st_next.full_d = 1'b1;
      st_next.empty_f = 1'b0;
      st_next.empty_d = 1'b0;
      st_next.in_rdy = 1'b0;
      st_next.in_rdy_d = 1'b0;
      st_next.half_f = 1'b1;
      st_next.afull_f = 1'b1;
      st_next.aempty_f = 1'b0;
    end else begin
      // offset pointers keep their place across pauses in loading
      if (off_wr) begin
        unique case (st_reg.osel_w)
          dcfb_pkg::OSEL_EMPTY: begin
            st_next.empty_off = data_in[11:0];
            st_next.osel_w = dcfb_pkg::OSEL_FULL;
          end
          dcfb_pkg::OSEL_FULL: begin
            st_next.full_off = data_in[11:0];
            st_next.osel_w = dcfb_pkg::OSEL_EMPTY;
          end
          default: begin
            st_next.osel_w = dcfb_pkg::OSEL_EMPTY;
          end
        endcase
      end
      if (off_rd) begin
        unique case (st_reg.osel_r)
          dcfb_pkg::OSEL_EMPTY: begin
            st_next.out_data = {6'h00, st_reg.empty_off};
            st_next.osel_r = dcfb_pkg::OSEL_FULL;
          end
          dcfb_pkg::OSEL_FULL: begin
            st_next.out_data = {6'h00, st_reg.full_off};
            st_next.osel_r = dcfb_pkg::OSEL_EMPTY;
          end
          default: begin
            st_next.osel_r = dcfb_pkg::OSEL_EMPTY;
          end
        endcase
      end
      if (pop) begin
        st_next.out_data = store_data;
      end
      if (fall_load) begin
        st_next.out_valid = 1'b1;
      end else if (fall_read && !store_valid) begin
        st_next.out_valid = 1'b0;
      end
      if (st_reg.fall_mode && !st_reg.out_valid && store_valid
          && st_reg.fall_stage != dcfb_pkg::FALL_STAGES) begin
        st_next.fall_stage = st_reg.fall_stage + 2'h1;
      end else if (!store_valid || st_reg.out_valid || fall_load) begin
        st_next.fall_stage = 2'h0;
      end
      level_nx = dcfb_fill(cnt_nx, st_next.out_valid);
      lv_next = dcfb_levels(level_nx, st_reg.fall_mode, st_next.empty_off, st_next.full_off);
      st_next.full_f = (cnt_nx != dcfb_pkg::DEPTH_LEVEL[8:0]);
      st_next.in_rdy = (level_nx == dcfb_pkg::DEPTH_LEVEL + 13'h0001);
      st_next.empty_f = (cnt_nx != 9'h000);
      st_next.half_f = lv_next[2];
      st_next.afull_f = lv_next[1];
      st_next.aempty_f = lv_next[0];
      st_next.full_d = st_reg.full_f;
      st_next.empty_d = st_reg.empty_f;
      st_next.in_rdy_d = st_reg.in_rdy;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // asynchronous partial flags follow the live count; sync ones the registered copy
  assign lv_now = dcfb_levels(dcfb_fill(cnt, st_reg.out_valid), st_reg.fall_mode,
                              st_reg.empty_off, st_reg.full_off);

  assign data_out = st_reg.out_data;
  assign data_out_oe = !output_enable_n;
  // one shared clock serves both sides, so no pointer crossing is needed
  assign full_flag = st_reg.fall_mode || (st_reg.dbl ? st_reg.full_d : st_reg.full_f);
  assign input_ready = st_reg.fall_mode && st_reg.in_rdy_d;
  assign empty_flag = !st_reg.fall_mode && (st_reg.dbl ? st_reg.empty_d : st_reg.empty_f);
  assign output_ready = !st_reg.fall_mode || !st_reg.out_valid;
  assign half_full_flag = (!st_reg.clr_s) || (st_reg.part_sync ? st_reg.half_f : lv_now[2]);
  assign almost_full_flag = (!st_reg.clr_s) || (st_reg.part_sync ? st_reg.afull_f : lv_now[1]);
  assign almost_empty_flag = st_reg.clr_s && (st_reg.part_sync ? st_reg.aempty_f : lv_now[0]);

  default clocking dcfb_cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_clear_ptrs;
    !st_reg.clr_s |=> (cnt == 9'h000);
  endproperty
  a_clear_ptrs: assert property (p_clear_ptrs) else $error("clear left data in the bank");

  property p_clear_levels;
    !st_reg.clr_s |=> half_full_flag && almost_full_flag && !almost_empty_flag;
  endproperty
  a_clear_levels: assert property (p_clear_levels) else $error("partial flags on clear");

  property p_clear_edges;
    !st_reg.clr_s |=> full_flag && !empty_flag && output_ready && !input_ready;
  endproperty
  a_clear_edges: assert property (p_clear_edges) else $error("full or empty on clear");

  property p_clear_regs;
    !st_reg.clr_s |=> (data_out == 18'h0_0000) && (st_reg.empty_off == dcfb_pkg::EMPTY_OFF_DEF)
                      && (st_reg.full_off == dcfb_pkg::FULL_OFF_DEF);
  endproperty
  a_clear_regs: assert property (p_clear_regs) else $error("output or offsets not reset");

  property p_write_counts;
    st_reg.clr_s && !st_reg.fall_mode && st_reg.full_f && !write_enable_n && offset_load_n
      && read_enable_n |=> (cnt == $past(cnt) + 9'h001);
  endproperty
  a_write_counts: assert property (p_write_counts) else $error("write did not store a word");

  property p_full_blocks;
    st_reg.clr_s && !st_reg.fall_mode && !st_reg.full_f && read_enable_n |=> $stable(cnt);
  endproperty
  a_full_blocks: assert property (p_full_blocks) else $error("write taken while full");

  property p_read_loads;
    st_reg.clr_s && !st_reg.fall_mode && st_reg.empty_f && !read_enable_n && offset_load_n
      |=> (data_out == $past(store_data)) && (cnt == $past(cnt) - 9'h001 + 9'($past(push)));
  endproperty
  a_read_loads: assert property (p_read_loads) else $error("read did not load next word");

  property p_read_holds;
    st_reg.clr_s && !st_reg.fall_mode && read_enable_n |=> !st_reg.clr_s || $stable(data_out);
  endproperty
  a_read_holds: assert property (p_read_holds) else $error("output changed without read");

  property p_fall_first;
    st_reg.clr_s && st_reg.fall_mode && !st_reg.out_valid && (cnt == 9'h000) && push
      |-> ##1 (output_ready [*3]) ##1 !output_ready;
  endproperty
  a_fall_first: assert property (p_fall_first) else $error("first word not on third edge");

  property p_fall_last;
    st_reg.clr_s && st_reg.fall_mode && st_reg.out_valid && (cnt == 9'h000) && !read_enable_n
      && offset_load_n |=> output_ready && $stable(data_out);
  endproperty
  a_fall_last: assert property (p_fall_last) else $error("last read did not raise ready");

  property p_offset_write;
    st_reg.clr_s && !offset_load_n && !write_enable_n && (st_reg.osel_w == dcfb_pkg::OSEL_EMPTY)
      |=> (st_reg.empty_off == $past(data_in[11:0])) && (st_reg.osel_w == dcfb_pkg::OSEL_FULL);
  endproperty
  a_offset_write: assert property (p_offset_write) else $error("empty offset not written");

  property p_load_freeze;
    st_reg.clr_s && !st_reg.fall_mode && !offset_load_n && write_enable_n && read_enable_n
      |=> $stable(cnt) && $stable(st_reg.osel_w);
  endproperty
  a_load_freeze: assert property (p_load_freeze) else $error("pointer moved on idle");

  property p_no_fall_readback;
    st_reg.clr_s && st_reg.fall_mode && !offset_load_n && !read_enable_n
      |=> $stable(st_reg.osel_r);
  endproperty
  a_no_fall_readback: assert property (p_no_fall_readback) else $error("offset readback");

  c_full: cover property (st_reg.clr_s && !st_reg.fall_mode && !full_flag);
  c_fall_first: cover property (st_reg.fall_mode && $rose(st_reg.out_valid));
  c_off_read: cover property (off_rd && st_reg.osel_r == dcfb_pkg::OSEL_FULL);
  c_empty_again: cover property (!st_reg.fall_mode && $fell(st_reg.empty_f));

endmodule

/* dcfb_pkg.sv */
// Purpose: shared constants and types for the fifo bank control block
// Assumes: one clock for the write and read sides, 18-bit data, 256-word bank
// Notes: offset defaults match the 256-word bank size
package dcfb_pkg;

  localparam int DATA_W = 18;
  localparam int DEPTH = 32'h0000_0100;
  localparam int CNT_W = 9;
  localparam int OFF_W = 12;

  // levels are compared at 13 bits so offsets plus one never wrap
  localparam logic [12:0] DEPTH_LEVEL = 13'h0100;
  localparam logic [12:0] HALF_LEVEL = 13'h0080;

  localparam logic [11:0] EMPTY_OFF_DEF = 12'h001F;
  localparam logic [11:0] FULL_OFF_DEF = 12'h001F;

  // strap positions inside the sampled strap vector
  localparam int STRAP_FIRST = 2;
  localparam int STRAP_CHAIN_RD = 1;
  localparam int STRAP_CHAIN_WR = 0;

  // fall-through waits this many edges with data present before loading
  localparam logic [1:0] FALL_STAGES = 2'h2;

  // which offset register the next offset access touches
  typedef enum logic [1:0] {
    OSEL_EMPTY = 2'b01,
    OSEL_FULL = 2'b10
  } dcfb_osel_e;

endpackage

/* dcfb_store.sv */
// Purpose: word storage of the bank, a plain synchronous fifo
// Assumes: rd_data is valid whenever rd_valid is high (show-ahead)
// Notes: clear returns both pointers to the first location
module dcfb_store #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 256
) (
  // clocking, reset and clear
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  // fill side
  input wire logic wr_valid,
  input wire logic [WIDTH-1:0] wr_data,
  output logic wr_ready,
  // drain side
  output logic rd_valid,
  output logic [WIDTH-1:0] rd_data,
  input wire logic rd_ready,
  // fill level
  output logic [$clog2(DEPTH):0] count
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } dcfb_store_s;

  logic [WIDTH-1:0] mem [DEPTH];
  dcfb_store_s st_reg;
  dcfb_store_s st_next;
  logic push;
  logic pop;

  assign wr_ready = (st_reg.count != DEPTH[AW:0]);
  assign rd_valid = (st_reg.count != '0);
  assign rd_data = mem[st_reg.rd_ptr];
  assign count = st_reg.count;
  assign push = wr_valid & wr_ready;
  assign pop = rd_ready & rd_valid;

  always_comb begin
    st_next = st_reg;
    if (clear) begin
      st_next = '0;
    end else begin
      if (push) begin
        st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
      end
      if (pop) begin
        st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
      end
      st_next.count = st_reg.count + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // memory has no reset; contents are never read before being written
  always_ff @(posedge clk) begin
    if (push && !clear) begin
      mem[st_reg.wr_ptr] <= wr_data;
    end
  end

endmodule

/* dcfb_peer.sv */
// Purpose: writer and reader logic on the far side of the fifo bank control block
// Assumes: every input of the block but clk and reset is driven here, just after a rising edge
// Notes: released data lines carry the inverse of the last word, never a stale copy
module dcfb_peer (
  // clocking
  input wire logic clk,
  // clear and straps
  output logic fifo_clear_n,
  output logic first_device_select,
  output logic chain_read_in,
  output logic chain_write_in,
  // write side
  output logic [17:0] data_in,
  output logic write_enable_n,
  output logic offset_load_n,
  // read side
  output logic read_enable_n,
  output logic output_enable_n
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    fifo_clear_n = 1'b1;
    {first_device_select, chain_read_in, chain_write_in} = 3'h0;
    data_in = 18'h0_0000;
    write_enable_n = 1'b1;
    offset_load_n = 1'b1;
    read_enable_n = 1'b1;
    output_enable_n = 1'b0;
  end

  // straps only move together with a clear, so the mode is never half changed
  task automatic clear_bank(input logic [2:0] mode);
    @(posedge clk);
    {first_device_select, chain_read_in, chain_write_in} <= mode;
    fifo_clear_n <= 1'b0;
    repeat (4) @(posedge clk);
    fifo_clear_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  // n consecutive edges of one kind of access, then everything released
  task automatic drive(input logic [17:0] d, input int n, input bit wr, input bit rd,
                       input bit load);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      data_in <= d + 18'(i);
      write_enable_n <= !wr;
      // an offset read never shares a cycle with an offset write
      read_enable_n <= !(rd && !(load && wr));
      offset_load_n <= !load;
    end
    @(posedge clk);
    write_enable_n <= 1'b1;
    read_enable_n <= 1'b1;
    offset_load_n <= 1'b1;
    data_in <= ~data_in;
  endtask

  task automatic set_oe(input logic v);
    @(posedge clk);
    output_enable_n <= v;
  endtask
endmodule

/* tb.sv */
// Purpose: self-checking bench for the fifo bank control block
// Assumes: one clock serves both sides; straps change only with a clear
// Notes: most flag checks let two idle edges pass; the buffered-flag scenario times its edges
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk;
  logic reset;
  logic fifo_clear_n, first_device_select, chain_read_in, chain_write_in;
  logic write_enable_n, offset_load_n, read_enable_n, output_enable_n;
  logic [17:0] data_in;
  logic [17:0] data_out;
  logic data_out_oe, full_flag, input_ready, empty_flag, output_ready;
  logic half_full_flag, almost_full_flag, almost_empty_flag;
  logic [6:0] flags;
  int mismatches;
  int compares;

  assign flags = {full_flag, input_ready, empty_flag, output_ready, half_full_flag,
                  almost_full_flag, almost_empty_flag};

  dcfb_peer dcfb_peer_inst (
    .clk, .fifo_clear_n, .first_device_select, .chain_read_in, .chain_write_in,
    .data_in, .write_enable_n, .offset_load_n, .read_enable_n, .output_enable_n
  );

  dcfb_bank_ctrl dcfb_bank_ctrl_inst (
    .clk, .reset, .fifo_clear_n, .first_device_select, .chain_read_in, .chain_write_in,
    .data_in, .write_enable_n, .offset_load_n, .read_enable_n, .output_enable_n,
    .data_out, .data_out_oe, .full_flag, .input_ready, .empty_flag, .output_ready,
    .half_full_flag, .almost_full_flag, .almost_empty_flag
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // flag vector: full, input ready, empty, output ready, half, almost full, almost empty
  task automatic chk_flags(input logic [6:0] e);
    repeat (2) @(posedge clk);
    #1;
    chk({11'h000, flags}, {11'h000, e});
  endtask

  task automatic chk_out(input logic [17:0] e);
    #1;
    chk(data_out, e);
  endtask

  task automatic op(input logic [17:0] d, input int n, input bit w, input bit r,
                    input bit l);
    dcfb_peer_inst.drive(d, n, w, r, l);
  endtask

  task automatic t_clear_std();
    dcfb_peer_inst.clear_bank(3'h0);
    chk_flags(7'h4E);
    chk_out(18'h0_0000);
  endtask

  task automatic t_basic();
    op(18'h0_0000, 1, 0, 1, 0);
    chk_out(18'h0_0000);
    op(18'h1_2340, 3, 1, 0, 0);
    chk_flags(7'h5E);
    for (int i = 0; i < 3; i++) begin
      op(18'h0_0000, 1, 0, 1, 0);
      chk_out(18'h1_2340 + 18'(i));
    end
    op(18'h0_0000, 2, 0, 0, 0);
    chk_out(18'h1_2342);
    chk_flags(7'h4E);
  endtask

  // fill with pauses at the half and almost-full boundaries, then drain
  task automatic t_fill();
    op(18'h0_1000, 128, 1, 0, 0);
    chk_flags(7'h5F);
    op(18'h0_1080, 1, 1, 0, 0);
    chk_flags(7'h5B);
    op(18'h0_1081, 95, 1, 0, 0);
    chk_flags(7'h5B);
    op(18'h0_10E0, 1, 1, 0, 0);
    chk_flags(7'h59);
    op(18'h0_10E1, 31, 1, 0, 0);
    chk_flags(7'h19);
    op(18'h3_FFFF, 1, 1, 0, 0);
    chk_flags(7'h19);
    op(18'h0_0000, 1, 0, 1, 0);
    chk_out(18'h0_1000);
    chk_flags(7'h59);
    for (int i = 1; i < 256; i++) begin
      op(18'h0_0000, 1, 0, 1, 0);
      chk_out(18'h0_1000 + 18'(i));
    end
    chk_flags(7'h4E);
    op(18'h0_0000, 1, 0, 1, 0);
    chk_out(18'h0_10FF);
  endtask

  task automatic t_offsets();
    op(18'h0_0000, 1, 0, 1, 1);
    chk_out(18'h0_001F);
    op(18'h0_0000, 1, 0, 1, 1);
    chk_out(18'h0_001F);
    op(18'h3_FABC, 2, 1, 0, 1);
    // an odd count of frozen edges would leave a wrongly moving pointer on full
    op(18'h1_1111, 3, 0, 0, 1);
    chk_flags(7'h4E);
    op(18'h0_0000, 1, 0, 1, 1);
    chk_out(18'h0_0ABC);
    op(18'h0_0000, 1, 0, 1, 1);
    chk_out(18'h0_0ABD);
    op(18'h0_0002, 1, 1, 0, 1);
    op(18'h0_0000, 1, 0, 0, 0);
    op(18'h0_0005, 1, 1, 0, 1);
    op(18'h0_0000, 1, 0, 1, 1);
    chk_out(18'h0_0002);
    op(18'h0_0000, 1, 0, 1, 1);
    chk_out(18'h0_0005);
    op(18'h1_5550, 3, 1, 0, 0);
    chk_flags(7'h5F);
  endtask

  task automatic t_oe();
    dcfb_peer_inst.set_oe(1'b1);
    #1;
    chk({17'h0_0000, data_out_oe}, 18'h0_0000);
    dcfb_peer_inst.set_oe(1'b0);
    #1;
    chk({17'h0_0000, data_out_oe}, 18'h0_0001);
  endtask

  // double-buffered flags lag the internal state by one more edge
  task automatic t_dbl();
    dcfb_peer_inst.clear_bank(3'h6);
    chk_flags(7'h4E);
    op(18'h0_0777, 1, 1, 0, 0);
    #1;
    chk({17'h0_0000, empty_flag}, 18'h0_0000);
    @(posedge clk);
    #1;
    chk({17'h0_0000, empty_flag}, 18'h0_0001);
    chk_flags(7'h5E);
    op(18'h0_0000, 1, 0, 1, 0);
    chk_out(18'h0_0777);
    chk_flags(7'h4E);
  endtask

  task automatic t_fall();
    dcfb_peer_inst.clear_bank(3'h1);
    chk_flags(7'h4E);
    chk_out(18'h0_0000);
    op(18'h2_AAAA, 1, 1, 0, 0);
    for (int k = 1; k <= 3; k++) begin
      @(posedge clk);
      #1;
      chk({17'h0_0000, output_ready}, (k == 3) ? 18'h0_0000 : 18'h0_0001);
    end
    chk(data_out, 18'h2_AAAA);
    op(18'h2_5555, 1, 1, 0, 0);
    op(18'h0_0000, 2, 0, 0, 0);
    chk_out(18'h2_AAAA);
    op(18'h0_0000, 1, 0, 1, 0);
    chk_flags(7'h46);
    chk_out(18'h2_5555);
    op(18'h0_0000, 1, 0, 1, 0);
    chk_flags(7'h4E);
    chk_out(18'h2_5555);
    op(18'h0_0000, 1, 0, 1, 1);
    chk_out(18'h2_5555);
    op(18'h2_0000, 257, 1, 0, 0);
    chk_flags(7'h61);
    op(18'h3_FFFF, 1, 1, 0, 0);
    chk_out(18'h2_0000);
    op(18'h0_0000, 1, 0, 1, 0);
    chk_flags(7'h41);
    chk_out(18'h2_0001);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    mismatches = 0;
    compares = 0;
    reset = 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_clear_std();
    t_basic();
    t_fill();
    t_offsets();
    t_oe();
    t_dbl();
    t_fall();
    tally_and_finish();
  end
endmodule
